// ---- rtl/smr_mode_regs.v ----
// Mode-register bank for addresses 02h to 09h
`timescale 1ns/1ps
`include "smr_regs.vh"

module smr_mode_regs #(
    parameter [7:0] MAKER_CODE   = 8'h5a, // Arbitrary value
    parameter [7:0] REV_PRIMARY  = 8'ha5, // Arbitrary value
    parameter [7:0] REV_SECOND   = 8'h3c, // Arbitrary value
    parameter [1:0] PREFETCH     = `SMR_TYPE_FOUR_BIT,
    parameter [3:0] DENSITY      = `SMR_DENS_4GB,
    parameter [1:0] IO_WIDTH     = `SMR_WIDTH_X32
) (
    // Clock and reset
    input  wire       i_mclk,
    input  wire       i_rstn,
    // Mode-register command port
    input  wire       i_mrw,
    input  wire       i_mrr,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    // Temperature sensor refresh-rate code
    input  wire [2:0] i_sensor_rate,
    // Read answer
    output reg  [7:0] o_rdata,
    output reg        o_rvalid,
    output reg        o_rhit,
    // Decoded configuration
    output reg  [3:0] o_latency_code,
    output reg  [3:0] o_drive_code,
    output reg  [2:0] o_refresh_rate,
    output reg        o_temp_update_flag,
    output reg        o_over_85c,
    output reg        o_derate,
    output reg        o_temp_limit
);

    // Stored settings and status
    reg  [3:0] latency_reg;
    reg  [3:0] drive_reg;
    reg  [2:0] rate_reg;
    reg        tuf_reg;

    // Next values of the stored state
    reg  [3:0] latency_next;
    reg  [3:0] drive_next;
    reg  [2:0] rate_next;
    reg        tuf_next;

    // Read answer next values
    reg  [7:0] rdata_next;
    reg        hit_next;
    reg        rvalid_next;

    // Status decode next values
    reg        hot_next;
    reg        derate_next;
    reg        limit_next;

    // Command decode
    wire       lat_write;
    wire       drv_write;
    wire       temp_read;
    wire       rate_change;

    // Only six latency pairs exist; every other code is reserved
    function lat_legal;
        input [3:0] c;
        begin
            case (c)
                `SMR_LAT_RL3_WL1: lat_legal = 1'b1;
                `SMR_LAT_RL4_WL2: lat_legal = 1'b1;
                `SMR_LAT_RL5_WL2: lat_legal = 1'b1;
                `SMR_LAT_RL6_WL3: lat_legal = 1'b1;
                `SMR_LAT_RL7_WL4: lat_legal = 1'b1;
                `SMR_LAT_RL8_WL4: lat_legal = 1'b1;
                default:          lat_legal = 1'b0;
            endcase
        end
    endfunction

    // Drive codes with a gap at 5; zero and above 7 are reserved
    function drv_legal;
        input [3:0] c;
        begin
            case (c)
                `SMR_DRV_34R:  drv_legal = 1'b1;
                `SMR_DRV_40R:  drv_legal = 1'b1;
                `SMR_DRV_48R:  drv_legal = 1'b1;
                `SMR_DRV_60R:  drv_legal = 1'b1;
                `SMR_DRV_80R:  drv_legal = 1'b1;
                `SMR_DRV_120R: drv_legal = 1'b1;
                default:       drv_legal = 1'b0;
            endcase
        end
    endfunction

    // Full eight-bit compare; aliases of a mode address must not match
    function addr_is;
        input [7:0] a;
        input [7:0] target;
        begin
            addr_is = (a == target);
        end
    endfunction

    // Only the quarter rate with derating asks for longer core timings
    function rate_needs_derate;
        input [2:0] r;
        begin
            case (r)
                `SMR_RATE_Q_DERATE: rate_needs_derate = 1'b1;
                default:            rate_needs_derate = 1'b0;
            endcase
        end
    endfunction

    // Both ends of the code range mean the operating limit is exceeded
    function rate_out_of_range;
        input [2:0] r;
        begin
            case (r)
                `SMR_RATE_LOW_LIMIT:  rate_out_of_range = 1'b1;
                `SMR_RATE_HIGH_LIMIT: rate_out_of_range = 1'b1;
                default:              rate_out_of_range = 1'b0;
            endcase
        end
    endfunction

    // Addresses that answer a read; write-only ones do not
    function read_hit;
        input [7:0] a;
        begin
            case (a)
                `SMR_ADDR_TEMP:     read_hit = 1'b1;
                `SMR_ADDR_MAKER:    read_hit = 1'b1;
                `SMR_ADDR_REV_PRI:  read_hit = 1'b1;
                `SMR_ADDR_REV_SEC:  read_hit = 1'b1;
                `SMR_ADDR_GEOMETRY: read_hit = 1'b1;
                `SMR_ADDR_TEST:     read_hit = 1'b1;
                default:            read_hit = 1'b0;
            endcase
        end
    endfunction

    // Command decode; a write and a read may share one edge
    assign lat_write   = i_mrw && addr_is(i_addr, `SMR_ADDR_LATENCY);
    assign drv_write   = i_mrw && addr_is(i_addr, `SMR_ADDR_IO_DRIVE);
    assign temp_read   = i_mrr && addr_is(i_addr, `SMR_ADDR_TEMP);
    assign rate_change = (i_sensor_rate != rate_reg);

    // Reserved latency codes are dropped, so the old setting stays
    always @* begin
        latency_next = latency_reg;
        if (lat_write && lat_legal(i_wdata[3:0])) begin
            latency_next = i_wdata[3:0];
        end
    end

    // Reserved drive codes are dropped as well
    always @* begin
        drive_next = drive_reg;
        if (drv_write && drv_legal(i_wdata[3:0])) begin
            drive_next = i_wdata[3:0];
        end
    end

    // Set beats clear: a change in the read cycle must not be lost
    always @* begin
        rate_next = i_sensor_rate;
        tuf_next  = tuf_reg;
        if (rate_change) begin
            tuf_next = 1'b1;
        end else if (temp_read) begin
            tuf_next = 1'b0;
        end
    end

    // Read mux; write-only, test and idle cycles read as zero
    always @* begin
        rdata_next = 8'h00;
        if (i_mrr) begin
            case (i_addr)
                `SMR_ADDR_TEMP:     rdata_next = {tuf_reg, `SMR_RSVD_MID4, rate_reg};
                `SMR_ADDR_MAKER:    rdata_next = MAKER_CODE;
                `SMR_ADDR_REV_PRI:  rdata_next = REV_PRIMARY;
                `SMR_ADDR_REV_SEC:  rdata_next = REV_SECOND;
                `SMR_ADDR_GEOMETRY: rdata_next = {IO_WIDTH, DENSITY, PREFETCH};
                default:            rdata_next = 8'h00;
            endcase
        end
    end

    // Read strobe qualifies the hit so idle cycles never report one
    always @* begin
        rvalid_next = i_mrr;
        hit_next    = i_mrr && read_hit(i_addr);
    end

    // Status decode from the stored rate, not the raw sensor code
    always @* begin
        hot_next    = rate_reg[`SMR_RATE_HOT_BIT];
        derate_next = rate_needs_derate(rate_reg);
        limit_next  = rate_out_of_range(rate_reg);
    end

    // Latency setting
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            latency_reg <= `SMR_LAT_RESET;
        end else begin
            latency_reg <= latency_next;
        end
    end

    // Drive setting
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            drive_reg <= `SMR_DRV_RESET;
        end else begin
            drive_reg <= drive_next;
        end
    end

    // Sensor code is taken as synchronous; no extra stage is added
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            rate_reg <= `SMR_RATE_X1;
        end else begin
            rate_reg <= rate_next;
        end
    end

    // Update flag
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            tuf_reg <= 1'b0;
        end else begin
            tuf_reg <= tuf_next;
        end
    end

    // Read answer stands for one cycle only
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_rdata  <= 8'h00;
            o_rvalid <= 1'b0;
            o_rhit   <= 1'b0;
        end else begin
            o_rdata  <= rdata_next;
            o_rvalid <= rvalid_next;
            o_rhit   <= hit_next;
        end
    end

    // Configuration outputs lag the stored setting by one cycle
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_latency_code <= `SMR_LAT_RESET;
            o_drive_code   <= `SMR_DRV_RESET;
        end else begin
            o_latency_code <= latency_reg;
            o_drive_code   <= drive_reg;
        end
    end

    // Rate and flag copies for the controller side
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_refresh_rate     <= `SMR_RATE_X1;
            o_temp_update_flag <= 1'b0;
        end else begin
            o_refresh_rate     <= rate_reg;
            o_temp_update_flag <= tuf_reg;
        end
    end

    // Decoded temperature indications
    always @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_over_85c   <= 1'b0;
            o_derate     <= 1'b0;
            o_temp_limit <= 1'b0;
        end else begin
            o_over_85c   <= hot_next;
            o_derate     <= derate_next;
            o_temp_limit <= limit_next;
        end
    end

endmodule

// ---- rtl/smr_regs.vh ----
// Mode-register bank address map, field layout and reset values
`ifndef SMR_REGS_VH
`define SMR_REGS_VH

`define SMR_ADDR_LATENCY     8'h02
`define SMR_ADDR_IO_DRIVE    8'h03
`define SMR_ADDR_TEMP        8'h04
`define SMR_ADDR_MAKER       8'h05
`define SMR_ADDR_REV_PRI     8'h06
`define SMR_ADDR_REV_SEC     8'h07
`define SMR_ADDR_GEOMETRY    8'h08
`define SMR_ADDR_TEST        8'h09

`define SMR_LAT_RESET        4'h1
`define SMR_LAT_MIN          4'h1
`define SMR_LAT_MAX          4'h6
`define SMR_LAT_RL3_WL1      4'h1
`define SMR_LAT_RL4_WL2      4'h2
`define SMR_LAT_RL5_WL2      4'h3
`define SMR_LAT_RL6_WL3      4'h4
`define SMR_LAT_RL7_WL4      4'h5
`define SMR_LAT_RL8_WL4      4'h6
`define SMR_DRV_RESET        4'h2
`define SMR_DRV_MIN          4'h1
`define SMR_DRV_MAX          4'h7
`define SMR_DRV_HOLE         4'h5
`define SMR_DRV_34R          4'h1
`define SMR_DRV_40R          4'h2
`define SMR_DRV_48R          4'h3
`define SMR_DRV_60R          4'h4
`define SMR_DRV_80R          4'h6
`define SMR_DRV_120R         4'h7

`define SMR_RATE_LOW_LIMIT   3'h0
`define SMR_RATE_X4          3'h1
`define SMR_RATE_X2          3'h2
`define SMR_RATE_X1          3'h3
`define SMR_RATE_RSVD        3'h4
`define SMR_RATE_Q_NODERATE  3'h5
`define SMR_RATE_Q_DERATE    3'h6
`define SMR_RATE_HIGH_LIMIT  3'h7
`define SMR_RATE_HOT_BIT     2

`define SMR_TUF_BIT          7
`define SMR_RSVD_HI4         4'h0
`define SMR_RSVD_MID4        4'h0

`define SMR_TYPE_FOUR_BIT    2'h0
`define SMR_TYPE_TWO_BIT     2'h1
`define SMR_DENS_4GB         4'h6
`define SMR_WIDTH_X32        2'h0

`endif

// ---- testbench/smr_ctl_model.sv ----
// Controller model issuing one mode-register command at a time
`timescale 1ns/1ps
module smr_ctl_model (
    input  wire       i_mclk,
    output reg        o_mrw,
    output reg        o_mrr,
    output reg  [7:0] o_addr,
    output reg  [7:0] o_wdata
);
    initial {o_mrw, o_mrr, o_addr, o_wdata} = 18'h0;
    task cmd(input w, input r, input [7:0] a, input [7:0] d);
        @(posedge i_mclk) #1;
        {o_mrw, o_mrr, o_addr, o_wdata} = {w, r, a, d};
        @(posedge i_mclk) #1;
        // Released lines show the inverse, not a stale match
        {o_mrw, o_mrr, o_addr, o_wdata} = {2'h0, ~a, ~d};
    endtask
endmodule

// ---- testbench/smr_mode_regs_chk.sv ----
// Port-level assertions for the mode-register bank
`timescale 1ns/1ps
module smr_chk (
    input wire i_mclk, i_rstn, i_mrr, o_rvalid, o_rhit,
    input wire o_temp_update_flag, o_over_85c, o_derate, o_temp_limit,
    input wire [7:0] i_addr, o_rdata,
    input wire [3:0] o_latency_code, o_drive_code,
    input wire [2:0] o_refresh_rate
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    rst_vals_a: assert property (disable iff (1'b0) !i_rstn |=> o_latency_code == 4'h1 && o_drive_code == 4'h2 && !o_temp_update_flag) else $error("bad reset values");
    rd_pulse_a: assert property (1 |=> o_rvalid == $past(i_mrr)) else $error("read answer timing");
    rd_hit_a: assert property (o_rvalid |-> o_rhit == ($past(i_addr) >= 8'h04 && $past(i_addr) <= 8'h09)) else $error("hit wrong");
    maker_id_a: assert property (i_mrr && i_addr == 8'h05 |=> o_rdata == 8'h5a) else $error("maker code wrong");
    lat_legal_a: assert property (o_latency_code >= 4'h1 && o_latency_code <= 4'h6) else $error("latency reserved");
    drv_legal_a: assert property (o_drive_code inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7}) else $error("drive reserved");
    derate_a: assert property (o_derate == (o_refresh_rate == 3'h6)) else $error("derate wrong");
    hot_bit_a: assert property (o_over_85c == o_refresh_rate[2]) else $error("hot flag wrong");
    limit_a: assert property (o_temp_limit == (o_refresh_rate inside {3'h0, 3'h7})) else $error("limit wrong");
    cover property (o_rvalid && o_rdata[7]);
    cover property (o_derate);
    cover property (o_temp_limit);
endmodule
bind smr_mode_regs smr_chk u_chk (.*);

// ---- testbench/tb_top.sv ----
// Self-checking bench for the mode-register bank
`timescale 1ns/1ps
module tb_top;
    reg i_mclk = 0, i_rstn = 0;
    reg [2:0] sens = 3'h3, cur = 3'h3;
    reg [31:0] lf = 32'he4657c5d;
    wire mrw, mrr, rv, hit, temp_update_flag, hot, der, lim;
    wire [7:0] a, d, rd;
    wire [3:0] lat, drv;
    wire [2:0] rate;
    integer err_count = 0, check_count = 0, c, el = 1, ed = 2;
    smr_ctl_model ctl (.i_mclk(i_mclk), .o_mrw(mrw), .o_mrr(mrr), .o_addr(a), .o_wdata(d));
    smr_mode_regs dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_mrw(mrw), .i_mrr(mrr),
        .i_addr(a), .i_wdata(d), .i_sensor_rate(sens), .o_rdata(rd), .o_rvalid(rv),
        .o_rhit(hit), .o_latency_code(lat), .o_drive_code(drv), .o_refresh_rate(rate),
        .o_temp_update_flag(temp_update_flag), .o_over_85c(hot), .o_derate(der), .o_temp_limit(lim));
    initial forever #25 i_mclk = ~i_mclk;
    function [31:0] nx(input [31:0] v);
        nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rdc(input [7:0] ad, input [7:0] e, input h);
        ctl.cmd(0, 1, ad, 8'h0);
        chk({rv, hit, rd}, {1'b1, h, e});
    endtask
    task final_report;
        if (err_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #200000 err_count = err_count + 1;
        final_report;
    end
    initial begin
        repeat (12) @(posedge i_mclk);
        #1 chk({lat, drv, temp_update_flag}, {4'h1, 4'h2, 1'b0});
        i_rstn = 1;
        for (c = 0; c < 16; c = c + 1) begin
            lf = nx(lf);
            ctl.cmd(1, 0, 8'h02, {lf[7:4], c[3:0]});
            ctl.cmd(1, 0, 8'h03, {lf[11:8], c[3:0]});
            el = (c >= 1 && c <= 6) ? c : el;
            ed = (c >= 1 && c <= 7 && c != 5) ? c : ed;
            @(posedge i_mclk) #1 chk({lat, drv}, {el[3:0], ed[3:0]});
        end
        ctl.cmd(1, 0, 8'h05, 8'h00);
        rdc(8'h02, 8'h00, 0);
        rdc(8'h03, 8'h00, 0);
        rdc(8'h05, 8'h5a, 1);
        rdc(8'h06, 8'ha5, 1);
        rdc(8'h07, 8'h3c, 1);
        rdc(8'h08, 8'h18, 1);
        rdc(8'h09, 8'h00, 1);
        rdc(8'h0a, 8'h00, 0);
        for (c = 0; c < 24; c = c + 1) begin
            lf = nx(lf);
            @(posedge i_mclk) #1 sens = lf[2:0];
            repeat (3) @(posedge i_mclk);
            rdc(8'h04, {sens != cur, 4'h0, sens}, 1);
            cur = sens;
            rdc(8'h04, {1'b0, 4'h0, sens}, 1);
            chk({rate, hot, der, lim}, {sens, sens[2], sens == 3'h6, sens == 0 || sens == 7});
        end
        final_report;
    end
endmodule
